// ### inc/fcf_defs.vh
`ifndef FCF_DEFS_VH
`define FCF_DEFS_VH

// Register offsets
`define FCF_A_START8 16'hF107
`define FCF_A_BUFSEL 16'hF200
`define FCF_A_CMD 16'hF220
`define FCF_A_SYSCFG 16'hF221
`define FCF_A_INTSTAT 16'hF241

// Field positions
`define FCF_F_PAGE 7:2
`define FCF_F_SECT 1:0
`define FCF_F_BSA 11:8
`define FCF_F_BSC 1:0
`define FCF_F_BSA_LO 1:0
`define FCF_F_BSA_HI 3:2
`define FCF_C_RM 15
`define FCF_C_LAT 14:12
`define FCF_C_BURST 11:9
`define FCF_C_ECC 8
`define FCF_C_WPOL 7
`define FCF_C_CPOL 6
`define FCF_C_OE 5
`define FCF_C_WT 4
`define FCF_C_HS 2
`define FCF_C_WM 1
`define FCF_C_BLS 0
`define FCF_I_FLAG 15

// Reset values and masks
`define FCF_ZERO16 16'h0000
`define FCF_SYSCFG_RST 16'h40C0
`define FCF_SYSCFG_WMASK 16'hFFF6
`define FCF_PAGE_RST 6'h00
`define FCF_SECT_RST 2'h0
`define FCF_BSA_RST 4'h0
`define FCF_BSC_RST 2'h0
`define FCF_BSC_FOUR 2'h0
`define FCF_CNT_FOUR 3'h4
`define FCF_CNT_ONE 3'h1
`define FCF_BOOT_LOCKED 1'b0
`define FCF_FLAG_READY 1'b1
`define FCF_RM_RST 1'b0
`define FCF_LAT_RST 3'h4
`define FCF_BURST_RST 3'h0

// Command codes
`define FCF_CMD_LOAD 16'h0000
`define FCF_CMD_LOAD_SPARE 16'h0013
`define FCF_CMD_PROG 16'h0080
`define FCF_CMD_PROG_SPARE 16'h001A
`define FCF_CMD_COPYBACK 16'h001B
`define FCF_CMD_UNLOCK 16'h0023
`define FCF_CMD_LOCK 16'h002A
`define FCF_CMD_LOCK_TIGHT 16'h002C
`define FCF_CMD_UNLOCK_ALL 16'h0027
`define FCF_CMD_ERASE_VFY 16'h0071
`define FCF_CMD_CACHE_RD 16'h000E
`define FCF_CMD_CACHE_FIN 16'h000C
`define FCF_CMD_BURST_BLK 16'h000A
`define FCF_CMD_ERASE 16'h0094
`define FCF_CMD_MERASE 16'h0095
`define FCF_CMD_SUSPEND 16'h00B0
`define FCF_CMD_RESUME 16'h0030
`define FCF_CMD_CORE_RST 16'h00F0
`define FCF_CMD_HOT_RST 16'h00F3
`define FCF_CMD_OTP 16'h0065

// Operation kinds handed to the array core
`define FCF_K_NONE 5'h00
`define FCF_K_LOAD 5'h01
`define FCF_K_LOAD_SPARE 5'h02
`define FCF_K_PROG 5'h03
`define FCF_K_PROG_SPARE 5'h04
`define FCF_K_COPYBACK 5'h05
`define FCF_K_UNLOCK 5'h06
`define FCF_K_LOCK 5'h07
`define FCF_K_LOCK_TIGHT 5'h08
`define FCF_K_UNLOCK_ALL 5'h09
`define FCF_K_ERASE_VFY 5'h0A
`define FCF_K_CACHE_RD 5'h0B
`define FCF_K_CACHE_FIN 5'h0C
`define FCF_K_BURST_BLK 5'h0D
`define FCF_K_ERASE 5'h0E
`define FCF_K_MERASE 5'h0F
`define FCF_K_SUSPEND 5'h10
`define FCF_K_RESUME 5'h11
`define FCF_K_CORE_RST 5'h12
`define FCF_K_HOT_RST 5'h13
`define FCF_K_OTP 5'h14

`endif

// ### core/fcf_cmd_decode.v
`timescale 1ns/1ns
`include "fcf_defs.vh"

module fcf_cmd_decode (
    // Command in
    input wire [15:0] cmd,
    // Decode out
    output reg known,
    output reg [4:0] kind,
    output reg busy_ok
);

always @* begin
    known = 1'b1;
    busy_ok = 1'b0;
    case (cmd)
        `FCF_CMD_LOAD: kind = `FCF_K_LOAD;
        `FCF_CMD_LOAD_SPARE: kind = `FCF_K_LOAD_SPARE;
        `FCF_CMD_PROG: kind = `FCF_K_PROG;
        `FCF_CMD_PROG_SPARE: kind = `FCF_K_PROG_SPARE;
        `FCF_CMD_COPYBACK: kind = `FCF_K_COPYBACK;
        `FCF_CMD_ERASE_VFY: kind = `FCF_K_ERASE_VFY;
        `FCF_CMD_UNLOCK: kind = `FCF_K_UNLOCK;
        `FCF_CMD_LOCK: kind = `FCF_K_LOCK;
        `FCF_CMD_LOCK_TIGHT: kind = `FCF_K_LOCK_TIGHT;
        `FCF_CMD_UNLOCK_ALL: kind = `FCF_K_UNLOCK_ALL;
        `FCF_CMD_CACHE_RD: kind = `FCF_K_CACHE_RD;
        `FCF_CMD_CACHE_FIN: kind = `FCF_K_CACHE_FIN;
        `FCF_CMD_BURST_BLK: kind = `FCF_K_BURST_BLK;
        `FCF_CMD_ERASE: kind = `FCF_K_ERASE;
        `FCF_CMD_MERASE: kind = `FCF_K_MERASE;
        `FCF_CMD_SUSPEND: kind = `FCF_K_SUSPEND;
        `FCF_CMD_RESUME: kind = `FCF_K_RESUME;
        `FCF_CMD_OTP: kind = `FCF_K_OTP;
        `FCF_CMD_CORE_RST: begin
            kind = `FCF_K_CORE_RST;
            busy_ok = 1'b1;
        end
        `FCF_CMD_HOT_RST: begin
            kind = `FCF_K_HOT_RST;
            busy_ok = 1'b1;
        end
        default: begin
            kind = `FCF_K_NONE;
            known = 1'b0;
        end
    endcase
end

endmodule // fcf_cmd_decode

// ### core/fcf_buf_stepper.v
`timescale 1ns/1ns
`include "fcf_defs.vh"

module fcf_buf_stepper (
    // Clock and reset
    input wire sys_clk,
    input wire clr,
    input wire ce,
    // Control
    input wire load,
    input wire [3:0] bsa_in,
    input wire [1:0] bsc_in,
    input wire step,
    // State out
    output reg [3:0] buf_addr_q,
    output reg [2:0] remain_q
);

always @(posedge sys_clk) begin
    if (clr) begin
        buf_addr_q <= `FCF_BSA_RST;
        remain_q <= 3'h0;
    end else if (ce) begin
        if (load) begin
            buf_addr_q <= bsa_in;
            remain_q <= (bsc_in == `FCF_BSC_FOUR) ? `FCF_CNT_FOUR : {1'b0, bsc_in};
        end else if (step && remain_q != 3'h0) begin
            // Low bits wrap inside the selected buffer, upper bits hold
            buf_addr_q[`FCF_F_BSA_LO] <= buf_addr_q[`FCF_F_BSA_LO] + 2'h1;
            remain_q <= remain_q - `FCF_CNT_ONE;
        end
    end
end

endmodule // fcf_buf_stepper

// ### core/fcf_front_end.v
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "fcf_defs.vh"

module fcf_front_end (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    input wire ce,
    // Register port
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wr_data,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rd_data,
    // Array core requests
    output reg core_start,
    output reg core_reset,
    output reg [15:0] core_cmd,
    output reg [4:0] core_kind,
    output reg [5:0] core_page,
    output reg [1:0] core_sector,
    // Array core answers
    input wire core_done,
    input wire core_sector_step,
    // Transfer buffer position
    output wire [3:0] buf_addr,
    output wire [2:0] buf_remain,
    // Configuration to burst and correction logic
    output reg cfg_read_sync,
    output reg [2:0] cfg_latency,
    output reg [2:0] cfg_burst_size,
    output reg cfg_ecc_bypass,
    output reg cfg_wait_timing,
    output reg cfg_high_speed,
    output reg cfg_write_sync,
    // Wait level from burst logic
    input wire wait_ready,
    // Pins
    output reg int_pin_out,
    output reg int_pin_oe_n,
    output reg wait_pin_out,
    output reg wait_pin_oe_n,
    // Status
    output reg busy
);

////////////////////////////////////////////////////////////////////////
// States

// One-hot codes; any other pattern falls back to ready
localparam [1:0] ST_READY = 2'b01;
localparam [1:0] ST_BUSY = 2'b10;

reg [1:0] state_q;
reg [1:0] state_d;
reg flag_q;
reg flag_d;
reg [15:0] rd_d;
reg [5:0] page_q;
reg [1:0] sect_q;
reg [3:0] bsa_q;
reg [1:0] bsc_q;
reg [15:0] cmd_q;
reg [15:0] cfg_q;

wire dec_known;
wire [4:0] dec_kind;
wire dec_busy_ok;

////////////////////////////////////////////////////////////////////////
// Address decode

// Unmapped offsets match no select and are dropped
wire sel_start8 = reg_addr == `FCF_A_START8;
wire sel_bufsel = reg_addr == `FCF_A_BUFSEL;
wire sel_cmd = reg_addr == `FCF_A_CMD;
wire sel_syscfg = reg_addr == `FCF_A_SYSCFG;
wire sel_intstat = reg_addr == `FCF_A_INTSTAT;

wire cmd_wr = reg_wr && sel_cmd;
wire is_ready = state_q == ST_READY;
// Unknown codes are dropped so the core never sees an undefined kind
wire cmd_take = cmd_wr && dec_known && (is_ready || dec_busy_ok);
wire hot_rst = cmd_take && reg_wr_data == `FCF_CMD_HOT_RST;
wire core_rst_cmd = cmd_take && reg_wr_data == `FCF_CMD_CORE_RST;
wire op_start = cmd_take && !hot_rst && !core_rst_cmd;
// Hot reset shares the power-on clear path of the state, flag, address, command, config and buffer stepper registers; other output registers clear on rst only
wire clr = rst || hot_rst;

////////////////////////////////////////////////////////////////////////
// Command decoder

fcf_cmd_decode u_decode (
    .cmd(reg_wr_data),
    .known(dec_known),
    .kind(dec_kind),
    .busy_ok(dec_busy_ok)
);

////////////////////////////////////////////////////////////////////////
// Transfer buffer stepping

// Position reloads on every accepted operation other than core reset and hot reset, so no stale count carries over
fcf_buf_stepper u_stepper (
    .sys_clk(sys_clk),
    .clr(clr),
    .ce(ce),
    .load(op_start),
    .bsa_in(bsa_q),
    .bsc_in(bsc_q),
    .step(core_sector_step),
    .buf_addr_q(buf_addr),
    .remain_q(buf_remain)
);

////////////////////////////////////////////////////////////////////////
// Address registers

always @(posedge sys_clk) begin
    if (clr) begin
        page_q <= `FCF_PAGE_RST;
        sect_q <= `FCF_SECT_RST;
        bsa_q <= `FCF_BSA_RST;
        bsc_q <= `FCF_BSC_RST;
    end else if (ce) begin
        // Reserved bits are not stored, so they read back as zero
        if (reg_wr && sel_start8) begin
            page_q <= reg_wr_data[`FCF_F_PAGE];
            sect_q <= reg_wr_data[`FCF_F_SECT];
        end
        if (reg_wr && sel_bufsel) begin
            // Top bit boot or data, next data buffer, low bits sector
            bsa_q <= reg_wr_data[`FCF_F_BSA];
            bsc_q <= reg_wr_data[`FCF_F_BSC];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Command and configuration registers

always @(posedge sys_clk) begin
    if (clr) begin
        cmd_q <= `FCF_ZERO16;
        cfg_q <= `FCF_SYSCFG_RST;
    end else if (ce) begin
        if (cmd_take) begin
            cmd_q <= reg_wr_data;
        end
        if (reg_wr && sel_syscfg) begin
            // Read-only bits 3 and 0 never stored
            cfg_q <= reg_wr_data & `FCF_SYSCFG_WMASK;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Operation state

always @* begin
    state_d = state_q;
    case (state_q)
        ST_READY: begin
            if (cmd_take && !hot_rst) begin
                state_d = ST_BUSY;
            end
        end
        ST_BUSY: begin
            if (core_done) begin
                state_d = ST_READY;
            end
        end
        default: begin
            state_d = ST_READY;
        end
    endcase
    // Hot reset ends any running operation at once
    if (hot_rst) begin
        state_d = ST_READY;
    end
end

always @(posedge sys_clk) begin
    if (clr) begin
        state_q <= ST_READY;
    end else if (ce) begin
        state_q <= state_d;
    end
end

////////////////////////////////////////////////////////////////////////
// Completion flag

always @* begin
    flag_d = flag_q;
    // Completion outranks a clear in the same cycle
    if (state_q == ST_BUSY && core_done) begin
        flag_d = `FCF_FLAG_READY;
    end else if (cmd_take) begin
        flag_d = 1'b0;
    end else if (reg_wr && sel_intstat && !reg_wr_data[`FCF_I_FLAG]) begin
        flag_d = 1'b0;
    end
end

always @(posedge sys_clk) begin
    if (clr) begin
        flag_q <= `FCF_FLAG_READY;
    end else if (ce) begin
        flag_q <= flag_d;
    end
end

////////////////////////////////////////////////////////////////////////
// Requests to the array core
// Captured at accept so later host writes cannot disturb a running operation

always @(posedge sys_clk) begin
    if (rst) begin
        core_start <= 1'b0;
        core_reset <= 1'b0;
        core_cmd <= `FCF_ZERO16;
        core_kind <= `FCF_K_NONE;
        core_page <= `FCF_PAGE_RST;
        core_sector <= `FCF_SECT_RST;
    end else if (ce) begin
        core_start <= op_start;
        // Hot reset takes the array core back to its defaults too
        core_reset <= core_rst_cmd || hot_rst;
        if (cmd_take) begin
            core_cmd <= reg_wr_data;
            core_kind <= dec_kind;
            core_page <= page_q;
            core_sector <= sect_q;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Configuration outputs
// One cycle behind the register; burst logic samples them between transfers

always @(posedge sys_clk) begin
    if (rst) begin
        cfg_read_sync <= `FCF_RM_RST;
        cfg_latency <= `FCF_LAT_RST;
        cfg_burst_size <= `FCF_BURST_RST;
        cfg_ecc_bypass <= 1'b0;
        cfg_wait_timing <= 1'b0;
        cfg_high_speed <= 1'b0;
        cfg_write_sync <= 1'b0;
        busy <= 1'b0;
    end else if (ce) begin
        cfg_read_sync <= cfg_q[`FCF_C_RM];
        cfg_latency <= cfg_q[`FCF_C_LAT];
        cfg_burst_size <= cfg_q[`FCF_C_BURST];
        cfg_ecc_bypass <= cfg_q[`FCF_C_ECC];
        cfg_wait_timing <= cfg_q[`FCF_C_WT];
        cfg_high_speed <= cfg_q[`FCF_C_HS];
        cfg_write_sync <= cfg_q[`FCF_C_WM];
        // Busy comes from the next state so it rises as the flag falls
        busy <= state_d == ST_BUSY;
    end
end

////////////////////////////////////////////////////////////////////////
// Completion and wait pins

// Completion pin follows the flag, wait pin the wait level, one cycle late; a pin lag is harmless to the host
// Drive enable gates both pins, which stay undriven until it is set
always @(posedge sys_clk) begin
    if (rst) begin
        int_pin_out <= 1'b0;
        int_pin_oe_n <= 1'b1;
        wait_pin_out <= 1'b0;
        wait_pin_oe_n <= 1'b1;
    end else if (ce) begin
        int_pin_oe_n <= !cfg_q[`FCF_C_OE];
        wait_pin_oe_n <= !cfg_q[`FCF_C_OE];
        int_pin_out <= cfg_q[`FCF_C_CPOL] ? flag_q : !flag_q;
        wait_pin_out <= cfg_q[`FCF_C_WPOL] ? wait_ready : !wait_ready;
    end
end

////////////////////////////////////////////////////////////////////////
// Read port

always @* begin
    rd_d = `FCF_ZERO16;
    if (sel_start8) begin
        rd_d[`FCF_F_PAGE] = page_q;
        rd_d[`FCF_F_SECT] = sect_q;
    end
    if (sel_bufsel) begin
        rd_d[`FCF_F_BSA] = bsa_q;
        rd_d[`FCF_F_BSC] = bsc_q;
    end
    if (sel_cmd) begin
        rd_d = cmd_q;
    end
    if (sel_syscfg) begin
        rd_d = cfg_q;
        rd_d[`FCF_C_BLS] = `FCF_BOOT_LOCKED;
    end
    if (sel_intstat) begin
        rd_d[`FCF_I_FLAG] = flag_q;
    end
end

always @(posedge sys_clk) begin
    if (rst) begin
        reg_rd_data <= `FCF_ZERO16;
    end else if (ce) begin
        // Data stands one cycle only, zero between reads
        reg_rd_data <= reg_rd ? rd_d : `FCF_ZERO16;
    end
end

endmodule // fcf_front_end

// ### tb/fcf_front_end_assertions.sv
`timescale 1ns/1ns

module fcf_chk (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Register writes
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wr_data,
    input wire reg_wr,
    // Core link
    input wire core_start,
    input wire core_reset,
    input wire core_done,
    input wire core_sector_step,
    input wire [3:0] buf_addr,
    input wire [2:0] buf_remain,
    // Pin and status
    input wire int_pin_out,
    input wire int_pin_oe_n,
    input wire busy
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence cmd_wr_s;
        reg_wr && reg_addr == 16'hF220;
    endsequence
    sequence cfg_wr_s;
        reg_wr && reg_addr == 16'hF221;
    endsequence

    ////////////////////////////////////////////////////////////////
    start_busy_a: assert property (core_start |-> busy)
        else $error("start without busy");
    done_ready_a: assert property (busy && core_done && !reg_wr |=> !busy)
        else $error("busy after done");
    busy_refuse_a: assert property (cmd_wr_s ##0 busy && !core_done
        && reg_wr_data != 16'h00F0 && reg_wr_data != 16'h00F3 |=> !core_start && !core_reset)
        else $error("command taken while busy");
    core_reset_a: assert property (cmd_wr_s ##0 busy && reg_wr_data == 16'h00F0
        |=> busy ##[0:1] core_reset)
        else $error("core reset refused");
    hot_reset_a: assert property (cmd_wr_s ##0 reg_wr_data == 16'h00F3
        |=> !busy ##[0:1] core_reset)
        else $error("hot reset not taken");
    // Upper bits pick the buffer, so only the sector bits may move
    step_wrap_a: assert property (core_sector_step && buf_remain != 3'h0 && !reg_wr
        |=> buf_addr[3:2] == $past(buf_addr[3:2]) && buf_addr[1:0] == $past(buf_addr[1:0]) + 2'h1
        && buf_remain == $past(buf_remain) - 3'h1)
        else $error("buffer step wrong");
    drive_on_a: assert property (cfg_wr_s ##0 reg_wr_data[5] |-> ##[1:2] !int_pin_oe_n)
        else $error("pin not driven");
    pin_toggle_a: assert property ($fell(busy) && !int_pin_oe_n
        |=> int_pin_oe_n || int_pin_out != $past(int_pin_out))
        else $error("pin missed completion");
endmodule // fcf_chk

bind fcf_front_end fcf_chk chk (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
    .core_start(core_start), .core_reset(core_reset), .core_done(core_done),
    .core_sector_step(core_sector_step), .buf_addr(buf_addr), .buf_remain(buf_remain),
    .int_pin_out(int_pin_out), .int_pin_oe_n(int_pin_oe_n), .busy(busy)
);

// ### tb/fcf_core_model.sv
`timescale 1ns/1ns

module fcf_core_model (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Requests
    input wire core_start,
    input wire core_reset,
    input wire [2:0] buf_remain,
    input wire [7:0] op_len,
    // Answers
    output reg core_done,
    output reg core_sector_step
);
    reg [7:0] cnt_q;

    // A core reset also takes time, so it reloads the count too
    always @(posedge sys_clk) begin
        core_done <= 1'b0;
        core_sector_step <= 1'b0;
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (core_start || core_reset) begin
            cnt_q <= op_len;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            core_sector_step <= cnt_q[0] && buf_remain != 3'h0;
            core_done <= cnt_q == 8'h01;
        end
    end
endmodule // fcf_core_model

// ### tb/tb_top.sv
`timescale 1ns/1ns

module tb_top;
    reg sys_clk;
    reg rst;
    reg [15:0] reg_addr;
    reg [15:0] reg_wr_data;
    reg reg_wr;
    reg reg_rd;
    reg ce;
    reg wait_ready;
    reg [7:0] op_len;
    wire [15:0] reg_rd_data;
    wire core_start;
    wire core_reset;
    wire [4:0] core_kind;
    wire [15:0] core_cmd;
    wire [5:0] core_page;
    wire [1:0] core_sector;
    wire cfg_read_sync;
    wire [2:0] cfg_latency;
    wire [2:0] cfg_burst_size;
    wire cfg_ecc_bypass;
    wire cfg_wait_timing;
    wire cfg_high_speed;
    wire cfg_write_sync;
    wire [10:0] cfg_all = {cfg_read_sync, cfg_latency, cfg_burst_size, cfg_ecc_bypass,
        cfg_wait_timing, cfg_high_speed, cfg_write_sync};
    wire core_done;
    wire core_sector_step;
    wire [3:0] buf_addr;
    wire [2:0] buf_remain;
    wire int_pin_out;
    wire int_pin_oe_n;
    wire wait_pin_out;
    wire wait_pin_oe_n;
    wire busy;
    int err_total;
    int samples_checked;
    int i;
    reg [20:0] rows [0:18];

    fcf_front_end uut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .core_start(core_start),
        .core_reset(core_reset), .core_cmd(core_cmd), .core_kind(core_kind), .core_page(core_page),
        .core_sector(core_sector), .core_done(core_done), .core_sector_step(core_sector_step),
        .buf_addr(buf_addr), .buf_remain(buf_remain), .cfg_read_sync(cfg_read_sync),
        .cfg_latency(cfg_latency), .cfg_burst_size(cfg_burst_size), .cfg_ecc_bypass(cfg_ecc_bypass),
        .cfg_wait_timing(cfg_wait_timing), .cfg_high_speed(cfg_high_speed),
        .cfg_write_sync(cfg_write_sync), .wait_ready(wait_ready),
        .int_pin_out(int_pin_out), .int_pin_oe_n(int_pin_oe_n), .wait_pin_out(wait_pin_out),
        .wait_pin_oe_n(wait_pin_oe_n), .busy(busy)
    );
    fcf_core_model core (
        .sys_clk(sys_clk), .rst(rst), .core_start(core_start), .core_reset(core_reset),
        .buf_remain(buf_remain), .op_len(op_len), .core_done(core_done), .core_sector_step(core_sector_step)
    );

    ////////////////////////////////////////////////////////////////
    task chk(input [15:0] seen, input [15:0] exp, input string nm);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [15:0] a, input [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input [15:0] a, input [15:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rd_data, e, "read");
    endtask
    task cyc;
        @(posedge sys_clk);
        #1;
    endtask
    task idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            cyc();
            n++;
        end
        chk(16'(busy), 16'h0000, "idle");
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Tests take well under a thousand cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        close_out();
    end

    initial begin
        rows = '{{16'h0000, 5'h01}, {16'h0013, 5'h02}, {16'h0080, 5'h03}, {16'h001A, 5'h04},
            {16'h001B, 5'h05}, {16'h0023, 5'h06}, {16'h002A, 5'h07}, {16'h002C, 5'h08}, {16'h0027, 5'h09},
            {16'h0071, 5'h0A}, {16'h000E, 5'h0B}, {16'h000C, 5'h0C}, {16'h000A, 5'h0D}, {16'h0094, 5'h0E},
            {16'h0095, 5'h0F}, {16'h00B0, 5'h10}, {16'h0030, 5'h11}, {16'h00F0, 5'h12}, {16'h0065, 5'h14}};
        {rst, reg_wr, reg_rd, wait_ready, reg_addr, reg_wr_data} = {4'h8, 32'h0000_0000};
        ce = 1'b1;
        op_len = 8'd12;
        err_total = 0;
        samples_checked = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk(16'(int_pin_oe_n), 16'h0001, "oe after reset");
        rd(16'hF107, 16'h0000);
        rd(16'hF200, 16'h0000);
        rd(16'hF221, 16'h40C0);
        chk(16'(cfg_all), 16'h0200, "cfg reset");
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(16'hF107, 16'h00AA);
        @(posedge sys_clk);
        ce <= 1'b1;
        rd(16'hF107, 16'h0000);
        wr(16'hF107, 16'hFFFF);
        rd(16'hF107, 16'h00FF);
        wr(16'hF200, 16'hFFFF);
        rd(16'hF200, 16'h0F03);
        wr(16'hF221, 16'hFFFF);
        rd(16'hF221, 16'hFFF6);
        chk(16'(cfg_all), 16'h07FF, "cfg fields");
        cyc();
        chk(16'({wait_pin_oe_n, wait_pin_out}), 16'h0000, "wait pin");
        wr(16'hF221, 16'h40E0);
        cyc();
        chk(16'({int_pin_oe_n, int_pin_out}), 16'h0001, "pin ready");
        wr(16'hF107, 16'h0040);
        wr(16'hF200, 16'h0800);
        for (i = 0; i < 19; i++) begin
            wr(16'hF220, rows[i][20:5]);
            chk(16'(core_kind), 16'(rows[i][4:0]), "kind");
            chk(core_cmd, rows[i][20:5], "cmd");
            chk(16'({core_page, core_sector}), 16'h0040, "capture");
            cyc();
            chk(16'(int_pin_out), 16'h0000, "pin busy");
            idle();
            rd(16'hF241, 16'h8000);
            chk(16'(int_pin_out), 16'h0001, "pin done");
        end
        // Count 00 means four, so the wrap lands back on the start
        for (i = 0; i < 4; i++) begin
            wr(16'hF200, 16'h0D00 | 16'(i));
            wr(16'hF220, 16'h0000);
            chk(16'(buf_remain), (i == 0) ? 16'h0004 : 16'(i), "remain");
            idle();
            chk(16'(buf_addr), 16'({2'b11, 2'(1 + i)}), "wrap");
        end
        op_len <= 8'd60;
        wr(16'hF220, 16'h0080);
        wr(16'hF220, 16'h0013);
        rd(16'hF220, 16'h0080);
        wr(16'hF220, 16'h00F0);
        chk(16'({busy, core_kind}), 16'h0032, "core reset");
        idle();
        op_len <= 8'd12;
        wr(16'hF241, 16'h0000);
        cyc();
        chk(16'(int_pin_out), 16'h0000, "manual clear");
        wr(16'hF220, 16'h0000);
        chk(16'(busy), 16'h0001, "manual busy");
        idle();
        rd(16'hF241, 16'h8000);
        wr(16'hF221, 16'h4020);
        cyc();
        chk(16'(int_pin_out), 16'h0000, "inverted ready");
        chk(16'(wait_pin_out), 16'h0001, "wait inverted");
        wr(16'hF220, 16'h0080); // spare fill rides in buffer data, outside this block
        cyc();
        chk(16'(int_pin_out), 16'h0001, "inverted busy");
        idle();
        wr(16'hF221, 16'h40C0);
        cyc();
        chk(16'(int_pin_oe_n), 16'h0001, "drive off");
        wr(16'hF221, 16'h40E0);
        wr(16'hF107, 16'h0042);
        op_len <= 8'd60;
        wr(16'hF220, 16'h0080);
        wr(16'hF220, 16'h00F3);
        chk(16'(busy), 16'h0000, "hot reset");
        rd(16'hF107, 16'h0000);
        rd(16'hF221, 16'h40C0);
        chk(16'(int_pin_oe_n), 16'h0001, "hot oe");
        close_out();
    end
endmodule // tb_top
